/* File: design/mgs_pkg.sv */
// Shared constants, types and helpers of the multicast group snooping filter.
package mgs_pkg;

  // Message type codes carried in the top byte of the first message word.
  localparam logic [7:0]  T_QUERY     = 8'h11;
  localparam logic [7:0]  T_REPORT_V1 = 8'h12;
  localparam logic [7:0]  T_REPORT_V2 = 8'h16;
  localparam logic [7:0]  T_LEAVE     = 8'h17;
  localparam int          TYPE_MSB    = 31;

  // Multicast group address range and the all-hosts destination.
  localparam logic [31:0] MC_LOW      = 32'he0000000;
  localparam logic [31:0] MC_HIGH     = 32'hefffffff;
  localparam logic [31:0] ALL_HOSTS   = 32'he0000001;
  localparam logic [31:0] GRP_NONE    = 32'h00000000;
  localparam logic [7:0]  QUERY_TTL   = 8'h01;

  // Sizes and timer width.
  localparam int          NUM_PORTS   = 10;
  localparam int          NUM_GROUPS  = 16;
  localparam int          TMR_W       = 40;

  // Times in milliseconds and the matching counts of 10 ns cycles.
  localparam longint      CLK_PERIOD_NS      = 10;
  localparam longint      QUERY_INTERVAL_MS  = 125000;
  localparam longint      QUERY_RESP_MS      = 10000;
  localparam longint      LEAVE_WAIT_MS      = 1000;
  localparam longint      OTHER_QUERIER_MS   = 255000;
  localparam longint      QUERY_INTERVAL_CYC = QUERY_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint      QUERY_RESP_CYC     = (QUERY_RESP_MS * 1000000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
  localparam longint      LEAVE_WAIT_CYC     = (LEAVE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
  localparam longint      OTHER_QUERIER_CYC  = (OTHER_QUERIER_MS * 1000000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;

  // Classification of one received message.
  typedef enum logic [2:0] {
    K_OTHER,
    K_GEN_QUERY,
    K_GRP_QUERY,
    K_REPORT_V1,
    K_REPORT_V2,
    K_LEAVE
  } mgs_kind_t;

  // True when an address lies in the multicast group range.
  function automatic logic mgs_is_mc(input logic [31:0] a);
    return (a >= MC_LOW) && (a <= MC_HIGH);
  endfunction : mgs_is_mc

endpackage : mgs_pkg

/* File: design/mgs_parser.sv */
// Parser that classifies one two-word group management message.
`timescale 1ns/1ps
module mgs_parser #(
  parameter int PW = 4
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          reset,
  // Received message words.
  input  wire logic          in_valid,
  input  wire logic          in_first,
  input  wire logic [31:0]   in_word,
  input  wire logic [PW-1:0] in_port,
  // Classified message.
  output logic               msg_valid,
  output mgs_pkg::mgs_kind_t msg_kind,
  output logic [31:0]        msg_head,
  output logic [31:0]        msg_group,
  output logic [PW-1:0]      msg_port
);

  logic [31:0]        head_reg;
  logic               have_head_reg;
  logic               tail;
  logic               mc;
  mgs_pkg::mgs_kind_t kind_next;

  // Second word completes the message; any further word has no head and is dropped.
  assign tail = in_valid && !in_first && have_head_reg;
  assign mc   = mgs_pkg::mgs_is_mc(in_word);

  // Decode the type byte against the group word.
  always_comb begin
    kind_next = mgs_pkg::K_OTHER;
    case (head_reg[mgs_pkg::TYPE_MSB -: 8])
      mgs_pkg::T_QUERY: begin
        if (in_word == mgs_pkg::GRP_NONE) begin
          kind_next = mgs_pkg::K_GEN_QUERY;
        end else begin
          kind_next = mgs_pkg::K_GRP_QUERY;
        end
      end
      mgs_pkg::T_REPORT_V1: if (mc) kind_next = mgs_pkg::K_REPORT_V1;
      mgs_pkg::T_REPORT_V2: if (mc) kind_next = mgs_pkg::K_REPORT_V2;
      mgs_pkg::T_LEAVE:     if (mc) kind_next = mgs_pkg::K_LEAVE;
      default:              kind_next = mgs_pkg::K_OTHER;
    endcase
  end

  // Hold the first word until its group word arrives.
  always_ff @(posedge clk) begin
    if (reset) begin
      head_reg      <= '0;
      have_head_reg <= 1'b0;
    end else if (in_valid && in_first) begin
      head_reg      <= in_word;
      have_head_reg <= 1'b1;
    end else if (in_valid) begin
      have_head_reg <= 1'b0;
    end
  end

  // Registered result; fields hold until the next message completes.
  always_ff @(posedge clk) begin
    if (reset) begin
      msg_valid <= 1'b0;
      msg_kind  <= mgs_pkg::K_OTHER;
      msg_head  <= '0;
      msg_group <= '0;
      msg_port  <= '0;
    end else begin
      msg_valid <= tail;
      if (tail) begin
        msg_kind  <= kind_next;
        msg_head  <= head_reg;
        msg_group <= in_word;
        msg_port  <= in_port;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_tail_of(logic [7:0] t);
    in_valid && !in_first && have_head_reg && head_reg[31:24] == t;
  endsequence

  chk_general_query: assert property (
    s_tail_of(8'h11) and in_word == 32'h0 |=> msg_valid && msg_kind == mgs_pkg::K_GEN_QUERY)
    else $error("general query not classified");
  chk_group_query: assert property (
    s_tail_of(8'h11) and in_word != 32'h0 |=> msg_valid && msg_kind == mgs_pkg::K_GRP_QUERY)
    else $error("group query not classified");
  chk_leave_kind: assert property (
    s_tail_of(8'h17) and mc |=> msg_kind == mgs_pkg::K_LEAVE && msg_group == $past(in_word))
    else $error("leave not classified");
  chk_report_kind: assert property (
    s_tail_of(8'h16) and mc |=> msg_kind == mgs_pkg::K_REPORT_V2)
    else $error("report not classified");
  chk_fixed_size: assert property (
    in_valid && !in_first && !have_head_reg |=> !msg_valid)
    else $error("headless word produced a message");
  chk_group_range: assert property (
    msg_valid && msg_kind inside {mgs_pkg::K_REPORT_V1, mgs_pkg::K_REPORT_V2,
                                  mgs_pkg::K_LEAVE} |-> mgs_pkg::mgs_is_mc(msg_group))
    else $error("membership message outside multicast range");

endmodule : mgs_parser

/* File: design/mgs_snoop_filter.sv */
// Snooping filter: membership table, forwarding masks, processor copies and querier.
`timescale 1ns/1ps

// How it works
// - Copy recognised messages to management processor.
// - Multicast data reaches member ports only.
// - Type 11 with zero group: general query.
// - Type 11 with group: group query.
// - Type 17 is a version two leave.
// - Types 16 and 12 are joining reports.
// - Message is two fixed words, nothing more.
// - Only 224.0.0.0 to 239.255.255.255 is multicast.
// - General queries go to all-hosts; silence prunes.
// - Generated queries carry time-to-live of one.
// - Only one querier per LAN stays active.
// - Global enable switches all snooping.
// - Querier enable starts and stops periodic queries.
// - Immediate leave removes the port at once.
module mgs_snoop_filter #(
  parameter int     NP                 = mgs_pkg::NUM_PORTS,
  parameter int     NG                 = mgs_pkg::NUM_GROUPS,
  parameter longint QUERY_INTERVAL_CYC = mgs_pkg::QUERY_INTERVAL_CYC,
  parameter longint QUERY_RESP_CYC     = mgs_pkg::QUERY_RESP_CYC,
  parameter longint LEAVE_WAIT_CYC     = mgs_pkg::LEAVE_WAIT_CYC,
  parameter longint OTHER_QUERIER_CYC  = mgs_pkg::OTHER_QUERIER_CYC,
  localparam int    PW                 = $clog2(NP),
  localparam int    GW                 = $clog2(NG)
) (
  // Clock and reset.
  input  wire logic          CLK_SYS,
  input  wire logic          RESET,
  // Configuration.
  input  wire logic          SNOOPING_ENABLE,
  input  wire logic [NP-1:0] IMMEDIATE_LEAVE_ENABLE,
  input  wire logic          QUERY_GENERATOR_ENABLE,
  // Received group management messages.
  input  wire logic          RX_VALID,
  input  wire logic          RX_FIRST,
  input  wire logic [31:0]   RX_WORD,
  input  wire logic [PW-1:0] RX_PORT,
  // Copies to the management processor.
  output logic               CPU_VALID,
  output logic               CPU_FIRST,
  output logic [31:0]        CPU_WORD,
  output logic [PW-1:0]      CPU_PORT,
  // Forwarding lookup for multicast data.
  input  wire logic          FWD_REQ_VALID,
  input  wire logic [31:0]   FWD_REQ_GROUP,
  input  wire logic [PW-1:0] FWD_REQ_PORT,
  output logic               FWD_RSP_VALID,
  output logic [NP-1:0]      FWD_RSP_MASK,
  // Generated queries.
  output logic               QRY_VALID,
  output logic [7:0]         QRY_TYPE,
  output logic [31:0]        QRY_GROUP,
  output logic [31:0]        QRY_DEST,
  output logic [7:0]         QRY_TTL,
  output logic               QUERIER_ACTIVE
);

  localparam int TW = mgs_pkg::TMR_W;

  typedef enum logic [1:0] {QS_OFF, QS_ACTIVE, QS_YIELD} mgs_qstate_t;

  logic                         msg_valid;
  mgs_pkg::mgs_kind_t           msg_kind;
  logic [31:0]                  msg_head;
  logic [31:0]                  msg_group;
  logic [PW-1:0]                msg_port;
  logic [NG-1:0]                grp_valid_reg, valid_next;
  logic [NG-1:0][31:0]          grp_addr_reg, addr_next;
  logic [NG-1:0][NP-1:0]        grp_member_reg, mem_next;
  logic [NG-1:0][NP-1:0]        grp_age_reg, age_next;
  logic [NG-1:0][NP-1:0]        grp_leave_reg, lvp_next;
  logic [GW:0]                  mfind, ffind, rfind;
  logic [NP-1:0]                pbit, rbit;
  logic                         msg_ok, is_member, lq_fire, gq_fire, gq_event, foreign_q;
  logic                         age_expire, lv_expire, cp_second_reg;
  logic [TW-1:0]                qi_cnt_reg, age_cnt_reg, lv_cnt_reg, oq_cnt_reg;
  mgs_qstate_t                  qs_reg, qs_next;

  // Finds the entry holding a group; the top bit says whether one was found.
  function automatic logic [GW:0] find_grp(input logic [31:0] a);
    logic [GW:0] r;
    r = '0;
    for (int i = NG - 1; i >= 0; i--) begin
      if (grp_valid_reg[i] && grp_addr_reg[i] == a) r = {1'b1, GW'(i)};
    end
    return r;
  endfunction : find_grp

  // One-hot mask of a port number.
  function automatic logic [NP-1:0] port_bit(input logic [PW-1:0] p);
    return NP'(1) << p;
  endfunction : port_bit

  mgs_parser #(.PW(PW)) u_parser (
    .clk       (CLK_SYS),
    .reset     (RESET),
    .in_valid  (RX_VALID),
    .in_first  (RX_FIRST),
    .in_word   (RX_WORD),
    .in_port   (RX_PORT),
    .msg_valid (msg_valid),
    .msg_kind  (msg_kind),
    .msg_head  (msg_head),
    .msg_group (msg_group),
    .msg_port  (msg_port)
  );

  // Event decode; nothing is acted on while snooping is off.
  always_comb begin
    ffind = '0;
    for (int i = NG - 1; i >= 0; i--) begin
      if (!grp_valid_reg[i]) ffind = {1'b1, GW'(i)};
    end
  end
  assign mfind     = find_grp(msg_group);
  assign rfind     = find_grp(FWD_REQ_GROUP);
  assign pbit      = port_bit(msg_port);
  assign rbit      = port_bit(FWD_REQ_PORT);
  assign msg_ok    = msg_valid && SNOOPING_ENABLE && msg_kind != mgs_pkg::K_OTHER;
  assign is_member = mfind[GW] && (grp_member_reg[mfind[GW-1:0]] & pbit) != '0;
  assign lq_fire   = msg_ok && msg_kind == mgs_pkg::K_LEAVE && is_member
                     && !IMMEDIATE_LEAVE_ENABLE[msg_port];
  assign foreign_q = msg_ok && msg_kind inside {mgs_pkg::K_GEN_QUERY, mgs_pkg::K_GRP_QUERY};
  assign gq_fire   = qs_reg == QS_ACTIVE && qi_cnt_reg == '0 && !lq_fire && !foreign_q
                     && QUERY_GENERATOR_ENABLE && SNOOPING_ENABLE;
  // A general query heard from another querier ages the table just like our own.
  assign gq_event  = gq_fire || (msg_ok && msg_kind == mgs_pkg::K_GEN_QUERY);
  assign age_expire = age_cnt_reg == TW'(1);
  assign lv_expire  = lv_cnt_reg == TW'(1);

  // Next table contents: expiry first, then aging, then the message, so a report wins.
  always_comb begin
    valid_next = grp_valid_reg;
    addr_next  = grp_addr_reg;
    mem_next   = grp_member_reg;
    age_next   = grp_age_reg;
    lvp_next   = grp_leave_reg;
    for (int i = 0; i < NG; i++) begin
      if (age_expire) begin
        mem_next[i] = mem_next[i] & ~grp_age_reg[i];
        age_next[i] = '0;
      end
      if (lv_expire) begin
        mem_next[i] = mem_next[i] & ~grp_leave_reg[i];
        lvp_next[i] = '0;
      end
      if (gq_event) age_next[i] = mem_next[i];
      if (mem_next[i] == '0) valid_next[i] = 1'b0;
    end
    if (msg_ok) begin
      case (msg_kind)
        mgs_pkg::K_REPORT_V1, mgs_pkg::K_REPORT_V2: begin
          if (mfind[GW]) begin
            valid_next[mfind[GW-1:0]] = 1'b1;
            mem_next[mfind[GW-1:0]]   = mem_next[mfind[GW-1:0]] | pbit;
            age_next[mfind[GW-1:0]]   = age_next[mfind[GW-1:0]] & ~pbit;
            lvp_next[mfind[GW-1:0]]   = lvp_next[mfind[GW-1:0]] & ~pbit;
          end else if (ffind[GW]) begin
            valid_next[ffind[GW-1:0]] = 1'b1;
            addr_next[ffind[GW-1:0]]  = msg_group;
            mem_next[ffind[GW-1:0]]   = pbit;
            age_next[ffind[GW-1:0]]   = '0;
            lvp_next[ffind[GW-1:0]]   = '0;
          end
        end
        mgs_pkg::K_LEAVE: begin
          if (is_member && IMMEDIATE_LEAVE_ENABLE[msg_port]) begin
            mem_next[mfind[GW-1:0]] = mem_next[mfind[GW-1:0]] & ~pbit;
          end else if (is_member) begin
            lvp_next[mfind[GW-1:0]] = lvp_next[mfind[GW-1:0]] | pbit;
          end
        end
        default: ;
      endcase
    end
  end

  // Membership table; cleared while snooping is off so a restart begins clean.
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !SNOOPING_ENABLE) begin
      grp_valid_reg  <= '0;
      grp_addr_reg   <= '0;
      grp_member_reg <= '0;
      grp_age_reg    <= '0;
      grp_leave_reg  <= '0;
    end else begin
      grp_valid_reg  <= valid_next;
      grp_addr_reg   <= addr_next;
      grp_member_reg <= mem_next;
      grp_age_reg    <= age_next;
      grp_leave_reg  <= lvp_next;
    end
  end

  // Response windows; one shared window per kind keeps the table small.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      age_cnt_reg <= '0;
      lv_cnt_reg  <= '0;
    end else begin
      if (gq_event) age_cnt_reg <= TW'(QUERY_RESP_CYC);
      else if (age_cnt_reg != '0) age_cnt_reg <= age_cnt_reg - TW'(1);
      if (lq_fire) lv_cnt_reg <= TW'(LEAVE_WAIT_CYC);
      else if (lv_cnt_reg != '0) lv_cnt_reg <= lv_cnt_reg - TW'(1);
    end
  end

  // Querier role: any query heard from another device makes this one yield.
  always_comb begin
    qs_next = qs_reg;
    case (qs_reg)
      QS_OFF: if (QUERY_GENERATOR_ENABLE && SNOOPING_ENABLE) qs_next = QS_ACTIVE;
      QS_ACTIVE: begin
        if (!QUERY_GENERATOR_ENABLE || !SNOOPING_ENABLE) qs_next = QS_OFF;
        else if (foreign_q) qs_next = QS_YIELD;
      end
      QS_YIELD: begin
        if (!QUERY_GENERATOR_ENABLE || !SNOOPING_ENABLE) qs_next = QS_OFF;
        else if (oq_cnt_reg == TW'(1) && !foreign_q) qs_next = QS_ACTIVE;
      end
      default: qs_next = QS_OFF;
    endcase
  end

  // Role register and its timers; the first query goes out on taking the role.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      qs_reg     <= QS_OFF;
      qi_cnt_reg <= '0;
      oq_cnt_reg <= '0;
    end else begin
      qs_reg <= qs_next;
      if (qs_reg != QS_ACTIVE) qi_cnt_reg <= '0;
      else if (gq_fire) qi_cnt_reg <= TW'(QUERY_INTERVAL_CYC - 1);
      else if (qi_cnt_reg != '0) qi_cnt_reg <= qi_cnt_reg - TW'(1);
      if (foreign_q) oq_cnt_reg <= TW'(OTHER_QUERIER_CYC);
      else if (oq_cnt_reg != '0) oq_cnt_reg <= oq_cnt_reg - TW'(1);
    end
  end

  // Query output; a group query takes the slot and the general one waits a cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      QRY_VALID <= 1'b0;
      QRY_GROUP <= '0;
      QRY_DEST  <= '0;
    end else begin
      QRY_VALID <= lq_fire || gq_fire;
      if (lq_fire) begin
        QRY_GROUP <= msg_group;
        QRY_DEST  <= msg_group;
      end else if (gq_fire) begin
        QRY_GROUP <= mgs_pkg::GRP_NONE;
        QRY_DEST  <= mgs_pkg::ALL_HOSTS;
      end
    end
  end

  // Constant query fields and the querier flag, held in flops like the rest of the query.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      QRY_TYPE       <= '0;
      QRY_TTL        <= '0;
      QUERIER_ACTIVE <= 1'b0;
    end else begin
      QRY_TYPE       <= mgs_pkg::T_QUERY;
      QRY_TTL        <= mgs_pkg::QUERY_TTL;
      QUERIER_ACTIVE <= qs_next == QS_ACTIVE;
    end
  end

  // Processor copy: head word then group word, on back-to-back cycles.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CPU_VALID     <= 1'b0;
      CPU_FIRST     <= 1'b0;
      CPU_WORD      <= '0;
      CPU_PORT      <= '0;
      cp_second_reg <= 1'b0;
    end else if (msg_ok) begin
      CPU_VALID     <= 1'b1;
      CPU_FIRST     <= 1'b1;
      CPU_WORD      <= msg_head;
      CPU_PORT      <= msg_port;
      cp_second_reg <= 1'b1;
    end else begin
      CPU_VALID     <= cp_second_reg;
      CPU_FIRST     <= 1'b0;
      if (cp_second_reg) CPU_WORD <= msg_group;
      cp_second_reg <= 1'b0;
    end
  end

  // Forwarding mask: non-multicast or unsnooped traffic floods, groups reach members.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      FWD_RSP_VALID <= 1'b0;
      FWD_RSP_MASK  <= '0;
    end else begin
      FWD_RSP_VALID <= FWD_REQ_VALID;
      if (!SNOOPING_ENABLE || !mgs_pkg::mgs_is_mc(FWD_REQ_GROUP)) begin
        FWD_RSP_MASK <= ~rbit;
      end else if (rfind[GW]) begin
        FWD_RSP_MASK <= grp_member_reg[rfind[GW-1:0]] & ~rbit;
      end else begin
        FWD_RSP_MASK <= '0;
      end
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_copy_pair;
    CPU_VALID && CPU_FIRST ##1 CPU_VALID && !CPU_FIRST && CPU_WORD == $past(msg_group);
  endsequence

  chk_cpu_copy_pair: assert property (
    msg_ok |=> s_copy_pair)
    else $error("message not copied to processor");
  chk_fwd_no_member: assert property (
    FWD_REQ_VALID && SNOOPING_ENABLE && mgs_pkg::mgs_is_mc(FWD_REQ_GROUP) && !rfind[GW]
    |=> FWD_RSP_VALID && FWD_RSP_MASK == '0)
    else $error("unknown group flooded");
  chk_fwd_no_ingress: assert property (
    FWD_REQ_VALID |=> (FWD_RSP_MASK & $past(rbit)) == '0)
    else $error("frame sent back to its ingress port");
  chk_query_dest: assert property (
    QRY_VALID && QRY_GROUP == 32'h0 |-> QRY_DEST == 32'he0000001)
    else $error("general query not sent to all hosts");
  chk_query_ttl: assert property (
    QRY_VALID |-> QRY_TTL == 8'h01 && QRY_TYPE == 8'h11)
    else $error("query with wrong lifetime or type");
  chk_snoop_off: assert property (
    !SNOOPING_ENABLE [*2] |=> !CPU_VALID && grp_valid_reg == '0)
    else $error("snooping activity while disabled");
  chk_querier_off: assert property (
    !QUERY_GENERATOR_ENABLE |=> !(QRY_VALID && QRY_GROUP == 32'h0))
    else $error("general query while querier disabled");
  chk_querier_yield: assert property (
    qs_reg == QS_ACTIVE && foreign_q && QUERY_GENERATOR_ENABLE && SNOOPING_ENABLE
    |=> qs_reg == QS_YIELD [*2])
    else $error("querier did not yield");
  chk_fast_leave: assert property (
    msg_ok && msg_kind == mgs_pkg::K_LEAVE && is_member && IMMEDIATE_LEAVE_ENABLE[msg_port]
    |=> (grp_member_reg[$past(mfind[GW-1:0])] & $past(pbit)) == '0
    && !(QRY_VALID && QRY_GROUP != 32'h0))
    else $error("fast leave did not remove port");
  chk_slow_leave: assert property (
    lq_fire |=> QRY_VALID && QRY_GROUP == $past(msg_group)
    && (grp_member_reg[$past(mfind[GW-1:0])] & $past(pbit)) != '0)
    else $error("leave without group query or removed early");

endmodule : mgs_snoop_filter

/* File: dv/mgs_host_model.sv */
// Behavioural hosts and routers that send group messages into the filter.
`timescale 1ns/1ps
module mgs_host_model (
  // Clock.
  input  wire logic   clk,
  // Message words towards the filter.
  output logic        rx_valid,
  output logic        rx_first,
  output logic [31:0] rx_word,
  output logic [3:0]  rx_port
);
  // Lines start quiet before the first message.
  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_word  = 32'h00000000;
    rx_port  = 4'h0;
  end

  // Sends one fixed two-word message; the version one host on port 3 also calls it with a leave.
  task automatic send(input logic [7:0] typ, input logic [31:0] grp, input logic [3:0] prt);
    @(posedge clk);
    #1 rx_valid = 1'b1;
    rx_first = 1'b1;
    rx_word  = {typ, 8'h64, 16'h0000};
    rx_port  = prt;
    @(posedge clk);
    #1 rx_first = 1'b0;
    rx_word  = grp;
    @(posedge clk);
    #1 rx_valid = 1'b0;
    // Idle word is inverted so a stale group is never taken for a fresh one.
    rx_word  = ~rx_word;
  endtask : send

  // Sends one word with no head, as a message that runs past its two words would.
  task automatic stray(input logic [31:0] w);
    @(posedge clk);
    #1 rx_valid = 1'b1;
    rx_first = 1'b0;
    rx_word  = w;
    @(posedge clk);
    #1 rx_valid = 1'b0;
  endtask : stray
endmodule : mgs_host_model

/* File: dv/tb_top.sv */
// Self-checking testbench of the multicast group snooping filter.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] GRP = 32'he1020304;
  logic        clk_sys, reset, snoop_en, qgen_en, fwd_req, fwd_valid, qry_valid, q_act;
  logic        cpu_valid, cpu_first, rx_valid, rx_first;
  logic [9:0]  ile, fwd_mask;
  logic [3:0]  rx_port, fwd_prt, cpu_port;
  logic [31:0] rx_word, fwd_grp, cpu_word, qry_grp, qry_dst;
  logic [7:0]  qry_type, qry_ttl;
  logic [36:0] cpu_q[$];
  int          n_mismatch, check_count, qry_n;

  mgs_host_model host_u (.clk(clk_sys), .rx_valid(rx_valid), .rx_first(rx_first),
                         .rx_word(rx_word), .rx_port(rx_port));

  mgs_snoop_filter #(.QUERY_INTERVAL_CYC(200), .QUERY_RESP_CYC(50), .LEAVE_WAIT_CYC(20),
                     .OTHER_QUERIER_CYC(300)) dut_u (
    .CLK_SYS(clk_sys), .RESET(reset), .SNOOPING_ENABLE(snoop_en),
    .IMMEDIATE_LEAVE_ENABLE(ile), .QUERY_GENERATOR_ENABLE(qgen_en),
    .RX_VALID(rx_valid), .RX_FIRST(rx_first), .RX_WORD(rx_word), .RX_PORT(rx_port),
    .CPU_VALID(cpu_valid), .CPU_FIRST(cpu_first), .CPU_WORD(cpu_word), .CPU_PORT(cpu_port),
    .FWD_REQ_VALID(fwd_req), .FWD_REQ_GROUP(fwd_grp), .FWD_REQ_PORT(fwd_prt),
    .FWD_RSP_VALID(fwd_valid), .FWD_RSP_MASK(fwd_mask), .QRY_VALID(qry_valid),
    .QRY_TYPE(qry_type), .QRY_GROUP(qry_grp), .QRY_DEST(qry_dst), .QRY_TTL(qry_ttl),
    .QUERIER_ACTIVE(q_act));

  // Clock of 10 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Copies and queries are captured mid-cycle, so no check races the capture at an edge.
  always @(negedge clk_sys) begin
    if (cpu_valid === 1'b1) cpu_q.push_back({cpu_port, cpu_first, cpu_word});
    if (qry_valid === 1'b1) qry_n++;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // Issues one forwarding lookup and judges the answer one cycle later.
  task automatic lookup(input logic [31:0] grp, input logic [3:0] prt, input logic [9:0] exp);
    @(posedge clk_sys);
    #1 fwd_req = 1'b1;
    fwd_grp = grp;
    fwd_prt = prt;
    @(posedge clk_sys);
    #1 fwd_req = 1'b0;
    chk("fwd_valid", 32'h1, {31'h0, fwd_valid});
    chk("fwd_mask", {22'h0, exp}, {22'h0, fwd_mask});
  endtask : lookup

  // Checks the queued copies of one message, head then group, and the ingress port.
  task automatic copy(input logic [31:0] head, input logic [31:0] grp, input logic [3:0] prt);
    chk("copies", 32'h2, 32'(cpu_q.size()));
    if (cpu_q.size() >= 2) begin
      chk("copy_head", head, cpu_q[0][31:0]);
      chk("copy_first", 32'h1, {31'h0, cpu_q[0][32]});
      chk("copy_port", {28'h0, prt}, {28'h0, cpu_q[0][36:33]});
      chk("copy_group", grp, cpu_q[1][31:0]);
      chk("copy_second", 32'h0, {31'h0, cpu_q[1][32]});
    end
    cpu_q.delete();
  endtask : copy

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // Joins by both report versions, then lookups from member and other ports.
  task automatic t_join();
    host_u.send(mgs_pkg::T_REPORT_V2, GRP, 4'h2);
    repeat (3) @(posedge clk_sys);
    copy(32'h16640000, GRP, 4'h2);
    host_u.send(mgs_pkg::T_REPORT_V1, GRP, 4'h3);
    repeat (3) @(posedge clk_sys);
    copy(32'h12640000, GRP, 4'h3);
    lookup(GRP, 4'h0, 10'h00c);
    lookup(GRP, 4'h2, 10'h008);
    $display("test join done");
  endtask : t_join

  // Reports on both sides of the top edge of the multicast range.
  task automatic t_range();
    host_u.send(mgs_pkg::T_REPORT_V2, 32'hefffffff, 4'h4);
    host_u.send(mgs_pkg::T_REPORT_V2, 32'hf0000000, 4'h5);
    host_u.stray(GRP);
    repeat (3) @(posedge clk_sys);
    copy(32'h16640000, 32'hefffffff, 4'h4);
    lookup(32'hefffffff, 4'h0, 10'h010);
    lookup(32'hf0000000, 4'h0, 10'h3fe);
    $display("test range done");
  endtask : t_range

  // Immediate leave on one port, query-confirmed leave on another.
  task automatic t_leave();
    int n0;
    n0 = qry_n;
    host_u.send(mgs_pkg::T_LEAVE, GRP, 4'h2);
    repeat (3) @(posedge clk_sys);
    chk("no_grp_query", n0, qry_n);
    lookup(GRP, 4'h0, 10'h008);
    cpu_q.delete();
    host_u.send(mgs_pkg::T_LEAVE, GRP, 4'h3);
    repeat (2) @(posedge clk_sys);
    chk("grp_query", n0 + 1, qry_n);
    chk("q_group", GRP, qry_grp);
    chk("q_dest", GRP, qry_dst);
    chk("q_ttl", 32'h1, {24'h0, qry_ttl});
    lookup(GRP, 4'h0, 10'h008);
    repeat (25) @(posedge clk_sys);
    lookup(GRP, 4'h0, 10'h000);
    cpu_q.delete();
    $display("test leave done");
  endtask : t_leave

  // Own general queries, then yielding to a heard querier.
  task automatic t_querier();
    int n0;
    int i;
    n0 = qry_n;
    @(posedge clk_sys);
    #1 qgen_en = 1'b1;
    for (i = 0; i < 400 && qry_n == n0; i++) @(posedge clk_sys);
    if (qry_n == n0) begin
      n_mismatch++;
      $display("unexpected general query: expected one, seen none");
      test_done();
    end
    chk("q_type", 32'h11, {24'h0, qry_type});
    chk("q_group", 32'h0, qry_grp);
    chk("q_dest", mgs_pkg::ALL_HOSTS, qry_dst);
    chk("q_ttl", 32'h1, {24'h0, qry_ttl});
    chk("querier", 32'h1, {31'h0, q_act});
    cpu_q.delete();
    host_u.send(mgs_pkg::T_QUERY, 32'h0, 4'h5);
    repeat (3) @(posedge clk_sys);
    copy(32'h11640000, 32'h0, 4'h5);
    chk("querier", 32'h0, {31'h0, q_act});
    host_u.send(mgs_pkg::T_QUERY, GRP, 4'h5);
    repeat (3) @(posedge clk_sys);
    copy(32'h11640000, GRP, 4'h5);
    repeat (60) @(posedge clk_sys);
    lookup(32'hefffffff, 4'h0, 10'h000);
    $display("test querier done");
  endtask : t_querier

  // Snooping switched off floods data and copies nothing.
  task automatic t_off();
    #1 snoop_en = 1'b0;
    host_u.send(mgs_pkg::T_REPORT_V2, GRP, 4'h1);
    repeat (3) @(posedge clk_sys);
    chk("copies", 32'h0, 32'(cpu_q.size()));
    lookup(GRP, 4'h1, 10'h3fd);
    $display("test off done");
  endtask : t_off

  // Main sequence: reset for 16 cycles, then each scenario.
  initial begin
    n_mismatch = 0;
    check_count = 0;
    qry_n = 0;
    reset = 1'b1;
    snoop_en = 1'b1;
    qgen_en = 1'b0;
    ile = 10'h004;
    fwd_req = 1'b0;
    fwd_grp = 32'h0;
    fwd_prt = 4'h0;
    repeat (16) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_join();
    t_range();
    t_leave();
    t_querier();
    t_off();
    test_done();
  end
endmodule : tb_top
